// ===== common/remote_link_defines.vh
/*
  constants for the remote link configuration block: register offsets,
  field positions, addresses and timing counts.
  assumes a 40 MHz system clock and an apb register bus.
*/
`ifndef REMOTE_LINK_DEFINES_VH
`define REMOTE_LINK_DEFINES_VH

// register byte offsets
`define RL_OFF_CFG 12'h000
`define RL_OFF_ADDR 12'h004
`define RL_OFF_CTRL 12'h008
`define RL_OFF_STAT 12'h00C
`define RL_OFF_MASK 12'h010
`define RL_OFF_IRQ 12'h014
`define RL_OFF_RXADDR 12'h018
`define RL_OFF_MDM 12'h01C

// option switch positions (bit index = position - 1)
`define RL_OPT_PARITY 0
`define RL_OPT_BAUD_HI 1
`define RL_OPT_IF 4
`define RL_OPT_ERR 5

// ctrl register fields
`define RL_CTRL_LOCAL_BUSY 0
`define RL_CTRL_NVM_DONE 1
`define RL_CTRL_NVM_VALID 2
`define RL_CTRL_LAMP_STB 3

// irq status bit positions
`define RL_IRQ_KEY 0
`define RL_IRQ_REFRESH 1
`define RL_IRQ_ADDR_HIT 2
`define RL_IRQ_ERR_RESP 3
`define RL_IRQ_W 4

// addresses
`define RL_GLOBAL_ADDR 8'h00

// timing
`define RL_CLK_HZ 40000000
`define RL_REFRESH_MS 1000
`define RL_REFRESH_CYC ((`RL_CLK_HZ / 1000) * `RL_REFRESH_MS)
`define RL_MDM_BAUD 9600
`define RL_MDM_DIV (`RL_CLK_HZ / `RL_MDM_BAUD)

`endif

// ===== src/baud_tick_gen.v
/*
  baud tick generator: one-cycle enable pulse at the selected rate.
  assumes a synchronous reset and a divisor that changes only rarely.
*/
`timescale 1ns/1ps
module baud_tick_gen
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // divisor in system clocks per tick
  input wire [19:0] i_div,
  // tick output
  output reg o_tick
);

  reg [19:0] cnt_q;

  // free running down counter, reloads on the terminal count
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cnt_q <= 20'h00000;
      o_tick <= 1'b0;
    end
    else if (cnt_q == 20'h00000)
    begin
      cnt_q <= i_div - 20'h00001;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 20'h00001;
      o_tick <= 1'b0;
    end
  end

endmodule // baud_tick_gen

// ===== src/refresh_timer.v
/*
  refresh timer: one-cycle pulse once every period.
  assumes a synchronous reset; the period is a parameter so a bench can shorten it.
*/
`timescale 1ns/1ps
module refresh_timer
#(
  parameter [27:0] PERIOD = 28'h2625A00
)
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // pulse output
  output reg o_pulse
);

  reg [27:0] cnt_q;

  // counts up to the period then pulses
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cnt_q <= 28'h0000000;
      o_pulse <= 1'b0;
    end
    else if (cnt_q == PERIOD - 28'h0000001)
    begin
      cnt_q <= 28'h0000000;
      o_pulse <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 28'h0000001;
      o_pulse <= 1'b0;
    end
  end

endmodule // refresh_timer

// ===== src/remote_link_config.v
/*
  remote link configuration and control for the monitor-and-control unit.
  decodes option and address switch banks, runs the power-up restore
  sequence, times the display refresh, raises the keypad interrupt,
  filters received destination addresses and drives the modem control
  link settings. registers are reached over apb.
  assumes switch inputs are synchronous and a switch reads 1 when on.
*/
// Design decisions made here: the register addresses and the APB register port.
// Overview of operation
// (RL1) parity is even when option switch one is off, odd when on
// (RL2) switches two to four pick baud 110 up to 9600, off counts one
// (RL3) station address comes from address switches, position one is the msb
// (RL4) address zero is global and never a station address
// (RL5) option switch five on picks single-drop, off picks multidrop
// (RL6) multidrop holds at most 32 devices, single-drop exactly one
// (RL7) power-up tests backed memory, applies stored or default settings
// (RL8) switch six on sends error reply for commands blocked by local work
// (RL9) modem control link is fixed at 9600 baud even parity
// (RL10) only modems and channel units with unique addresses on modem link
// (RL11) keypad activity raises an interrupt to the processor
// (RL12) display refreshed each second, lamps and buzzer only on demand
// (RL13) external io interrupt arbitration stays disabled
// (RL14) messages for neither own nor global address are ignored
`timescale 1ns/1ps
`include "remote_link_defines.vh"
module remote_link_config
#(
  parameter [27:0] REFRESH_CYC = `RL_REFRESH_CYC
)
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // switch banks, bit n is position n+1, 1 = on
  input wire [7:0] i_option_switch_bank,
  input wire [7:0] i_address_switch_bank,
  // keypad activity level
  input wire i_key_active,
  // received destination address strobe
  input wire i_rx_addr_vld,
  input wire [7:0] i_rx_addr,
  // remote command rejected by local processing
  input wire i_cmd_blocked,
  // external remote link settings
  output reg o_ext_parity_odd,
  output reg [2:0] o_ext_baud_sel,
  output wire o_ext_baud_tick,
  output reg o_ext_if_single,
  output reg [7:0] o_station_addr,
  output reg o_addr_valid,
  output reg o_rx_accept,
  output reg o_err_resp,
  // modem control link settings
  output wire o_mdm_parity_odd,
  output wire o_mdm_baud_tick,
  // front panel
  output reg o_display_refresh,
  output reg o_lamp_update,
  // arbitration enable, always off
  output wire o_io_arb_en,
  // interrupt
  output wire o_irq
);

  ////////////////////////////////////////////////////////////////////
  // decoding helpers

  // baud switch code to divisor; off reads one, so code 7 is 9600
  function [19:0] baud_div;
    input [2:0] code;
    begin
      case (code)
        3'h0: baud_div = 20'd363636;
        3'h1: baud_div = 20'd266667;
        3'h2: baud_div = 20'd133333;
        3'h3: baud_div = 20'd66667;
        3'h4: baud_div = 20'd33333;
        3'h5: baud_div = 20'd16667;
        3'h6: baud_div = 20'd8333;
        default: baud_div = 20'd4167;
      endcase
    end
  endfunction

  // reverse bit order so position one lands in the msb
  function [7:0] bit_rev8;
    input [7:0] v;
    integer k;
    begin
      bit_rev8 = 8'h00;
      for (k = 0; k < 8; k = k + 1)
        bit_rev8[7 - k] = v[k];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // configuration state

  reg [2:0] cfg_baud_q;
  reg cfg_parity_q;
  reg cfg_if_q;
  reg cfg_err_q;
  reg local_busy_q;
  reg nvm_done_q;
  reg nvm_valid_q;
  reg [7:0] mask_q;
  reg [3:0] stat_q;
  reg [7:0] rx_last_q;
  reg key_prev_q;
  reg [1:0] boot_q;

  localparam [1:0] BOOT_WAIT = 2'h0;
  localparam [1:0] BOOT_RUN = 2'h1;

  wire [2:0] sw_baud = ~{i_option_switch_bank[1], i_option_switch_bank[2],
                         i_option_switch_bank[3]};
  wire [7:0] sw_addr = bit_rev8(i_address_switch_bank);

  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_en = i_psel & i_penable & ~i_pwrite;
  wire refresh_pulse;

  // power-up: config held from switches until software reports the memory test
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      boot_q <= BOOT_WAIT;
      cfg_baud_q <= 3'h7;
      cfg_parity_q <= 1'b0;
      cfg_if_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end
    else
    begin
      case (boot_q)
        BOOT_WAIT:
        begin
          // defaults come from switches; stored settings applied only if valid
          cfg_parity_q <= i_option_switch_bank[`RL_OPT_PARITY]; // RL1
          cfg_baud_q <= sw_baud; // RL2
          cfg_if_q <= i_option_switch_bank[`RL_OPT_IF]; // RL5
          cfg_err_q <= i_option_switch_bank[`RL_OPT_ERR]; // RL8
          if (nvm_done_q)
            boot_q <= BOOT_RUN; // RL7
        end
        BOOT_RUN:
        begin
          if (wr_en && i_paddr == `RL_OFF_CFG && nvm_valid_q)
          begin
            // stored configuration restore, only after a passing test
            cfg_parity_q <= i_pwdata[`RL_OPT_PARITY]; // RL7
            cfg_baud_q <= ~i_pwdata[3:1];
            cfg_if_q <= i_pwdata[`RL_OPT_IF];
            cfg_err_q <= i_pwdata[`RL_OPT_ERR];
          end
        end
        default: boot_q <= BOOT_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      local_busy_q <= 1'b0;
      nvm_done_q <= 1'b0;
      nvm_valid_q <= 1'b0;
      mask_q <= 8'h00;
      o_lamp_update <= 1'b0;
    end
    else
    begin
      o_lamp_update <= 1'b0;
      if (wr_en && i_paddr == `RL_OFF_CTRL)
      begin
        local_busy_q <= i_pwdata[`RL_CTRL_LOCAL_BUSY];
        // memory test result latches once, a later write cannot undo it
        if (!nvm_done_q)
        begin
          nvm_done_q <= i_pwdata[`RL_CTRL_NVM_DONE];
          nvm_valid_q <= i_pwdata[`RL_CTRL_NVM_VALID]; // RL7
        end
        o_lamp_update <= i_pwdata[`RL_CTRL_LAMP_STB]; // RL12
      end
      if (wr_en && i_paddr == `RL_OFF_MASK)
        mask_q <= i_pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs derived from configuration

  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_ext_parity_odd <= 1'b0;
      o_ext_baud_sel <= 3'h7;
      o_ext_if_single <= 1'b0;
      o_station_addr <= 8'h00;
      o_addr_valid <= 1'b0;
      o_rx_accept <= 1'b0;
      o_err_resp <= 1'b0;
      o_display_refresh <= 1'b0;
      rx_last_q <= 8'h00;
    end
    else
    begin
      o_ext_parity_odd <= cfg_parity_q; // RL1
      o_ext_baud_sel <= cfg_baud_q; // RL2
      o_ext_if_single <= cfg_if_q; // RL5
      o_station_addr <= sw_addr; // RL3
      // zero is the global address, flag the bank as not a station address
      o_addr_valid <= (sw_addr != `RL_GLOBAL_ADDR); // RL4
      o_rx_accept <= i_rx_addr_vld &&
                     (i_rx_addr == `RL_GLOBAL_ADDR ||
                      (i_rx_addr == sw_addr && sw_addr != `RL_GLOBAL_ADDR)); // RL14
      // error reply only when the remote command hit local use and it is enabled
      o_err_resp <= i_cmd_blocked & local_busy_q & cfg_err_q; // RL8
      o_display_refresh <= refresh_pulse; // RL12
      if (i_rx_addr_vld)
        rx_last_q <= i_rx_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by a read; a new event wins over the clear

  wire key_rise = i_key_active & ~key_prev_q;
  wire [3:0] ev = {i_cmd_blocked & local_busy_q & cfg_err_q,
                   o_rx_accept, refresh_pulse, key_rise};
  wire stat_rd = rd_en && i_paddr == `RL_OFF_STAT;

  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      stat_q <= 4'h0;
      key_prev_q <= 1'b0;
    end
    else
    begin
      key_prev_q <= i_key_active;
      stat_q <= (stat_rd ? 4'h0 : stat_q) | ev; // RL11
    end
  end

  assign o_irq = |(stat_q & mask_q[3:0]); // RL11
  assign o_io_arb_en = 1'b0; // RL13

  ////////////////////////////////////////////////////////////////////
  // apb read mux, zero wait states

  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  always @(posedge i_mclk)
  begin
    if (i_rst)
      o_prdata <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      case (i_paddr)
        `RL_OFF_CFG: o_prdata <= {26'h0, cfg_err_q, cfg_if_q, ~cfg_baud_q, cfg_parity_q};
        `RL_OFF_ADDR: o_prdata <= {23'h0, o_addr_valid, sw_addr};
        `RL_OFF_CTRL: o_prdata <= {29'h0, nvm_valid_q, nvm_done_q, local_busy_q};
        `RL_OFF_STAT: o_prdata <= {28'h0, stat_q};
        `RL_OFF_MASK: o_prdata <= {24'h0, mask_q};
        `RL_OFF_IRQ: o_prdata <= {31'h0, o_irq};
        `RL_OFF_RXADDR: o_prdata <= {24'h0, rx_last_q};
        `RL_OFF_MDM: o_prdata <= {16'h0, 16'd9600};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // rate generators

  baud_tick_gen u_ext_baud
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_div(baud_div(cfg_baud_q)),
    .o_tick(o_ext_baud_tick)
  );

  // modem link rate is fixed, never taken from switches
  baud_tick_gen u_mdm_baud
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_div(20'd4167), // RL9
    .o_tick(o_mdm_baud_tick)
  );

  assign o_mdm_parity_odd = 1'b0; // RL9

  refresh_timer #(.PERIOD(REFRESH_CYC)) u_refresh
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .o_pulse(refresh_pulse)
  );

endmodule // remote_link_config

// ===== tb/remote_link_config_monitor.sv
/*
  checker for remote_link_config, bound to its ports.
  assumes the switch banks stay steady while addresses are received.
*/
`timescale 1ns/1ps
module remote_link_config_monitor
#(
  parameter [27:0] REFRESH_CYC = 28'h0000064
)
(
  input wire i_mclk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire i_rx_addr_vld,
  input wire [7:0] i_rx_addr,
  input wire i_cmd_blocked,
  input wire [7:0] o_station_addr,
  input wire o_addr_valid,
  input wire o_rx_accept,
  input wire o_err_resp,
  input wire o_mdm_parity_odd,
  input wire o_display_refresh,
  input wire o_lamp_update,
  input wire o_io_arb_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // refresh spacing counter; the first pulse has no reference so it is skipped
  reg [27:0] gap_q;
  reg seen_q;
  always @(posedge i_mclk)
  begin
    gap_q <= (i_rst || o_display_refresh) ? 28'h0 : gap_q + 28'h1;
    seen_q <= i_rst ? 1'b0 : (seen_q | o_display_refresh);
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_mdm_even; o_mdm_parity_odd == 1'b0; endproperty
  a_mdm_even: assert property (p_mdm_even) else $error("modem parity not even");
  property p_arb_off; o_io_arb_en == 1'b0; endproperty
  a_arb_off: assert property (p_arb_off) else $error("arbitration enabled");
  property p_addr_valid; o_addr_valid == (o_station_addr != 8'h00); endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("zero taken as station");
  property p_global; i_rx_addr_vld && i_rx_addr == 8'h00 |=> o_rx_accept; endproperty
  a_global: assert property (p_global) else $error("global address dropped");
  property p_ignore;
    i_rx_addr_vld && i_rx_addr != 8'h00 && i_rx_addr != o_station_addr |=> !o_rx_accept;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign address accepted");
  property p_err_cause; o_err_resp |-> $past(i_cmd_blocked); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error reply without cause");
  property p_refresh; o_display_refresh && seen_q |-> gap_q == REFRESH_CYC - 28'h1; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh period wrong");
  property p_lamp;
    o_lamp_update |-> $past(i_psel && i_penable && i_pwrite && i_paddr == 12'h008 && i_pwdata[3]);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp update without request");
  c_accept: cover property (o_rx_accept);
  c_err: cover property (o_err_resp);
  c_lamp: cover property (o_lamp_update);
endmodule // remote_link_config_monitor
bind remote_link_config remote_link_config_monitor #(.REFRESH_CYC(REFRESH_CYC)) mon_i (.i_mclk,
  .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_rx_addr_vld, .i_rx_addr,
  .i_cmd_blocked, .o_station_addr, .o_addr_valid, .o_rx_accept, .o_err_resp, .o_mdm_parity_odd,
  .o_display_refresh, .o_lamp_update, .o_io_arb_en);

// ===== tb/remote_host_model.sv
/*
  remote host model: sends destination addresses and blocked commands.
  assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module remote_host_model
(
  input wire i_mclk,
  output logic o_vld,
  output logic [7:0] o_addr,
  output logic o_blocked
);
  initial
  begin
    o_vld = 1'b0;
    o_addr = 8'hA5;
    o_blocked = 1'b0;
  end
  // one address per call; callers keep addresses distinct per station
  task send(input [7:0] a);
    @(posedge i_mclk);
    o_vld <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_vld <= 1'b0;
    o_addr <= ~a; // released field shows junk, not the old value
  endtask
  // one blocked command pulse
  task block;
    @(posedge i_mclk);
    o_blocked <= 1'b1;
    @(posedge i_mclk);
    o_blocked <= 1'b0;
  endtask
endmodule // remote_host_model

// ===== tb/remote_link_config_test.sv
/*
  self-checking bench for remote_link_config over apb with a host model.
  assumes a refresh period shortened to 100 clocks.
*/
`timescale 1ns/1ps
module remote_link_config_test;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, key = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, e, m, sw, k;
  logic [7:0] opt = 0, adr = 0;
  wire vld, blk, rdy, err, par, sgl, va, acc, er, mp, rf, lu, arb, irq, et, mt;
  logic [7:0] rv;
  wire [7:0] ra, st;
  wire [2:0] bs;
  wire [31:0] prd;
  logic [31:0] qe[$], qm[$];
  int n_mismatch = 0, samples_checked = 0, cnt;
  always #12.5 clk = ~clk;
  remote_host_model remote_host_model_i (.i_mclk(clk), .o_vld(vld), .o_addr(ra), .o_blocked(blk));
  remote_link_config #(.REFRESH_CYC(28'h0000064)) remote_link_config_i (.i_mclk(clk),
    .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_pready(rdy), .o_prdata(prd), .o_pslverr(err), .i_option_switch_bank(opt),
    .i_address_switch_bank(adr), .i_key_active(key), .i_rx_addr_vld(vld), .i_rx_addr(ra),
    .i_cmd_blocked(blk), .o_ext_parity_odd(par), .o_ext_baud_sel(bs), .o_ext_baud_tick(et),
    .o_ext_if_single(sgl), .o_station_addr(st), .o_addr_valid(va), .o_rx_accept(acc),
    .o_err_resp(er), .o_mdm_parity_odd(mp), .o_mdm_baud_tick(mt), .o_display_refresh(rf),
    .o_lamp_update(lu), .o_io_arb_en(arb), .o_irq(irq));
  // spacing of each rate tick in clocks; only the last full gap is kept
  int ge = 0, gm = 0, le = 0, lm = 0;
  always @(posedge clk)
  begin
    ge <= et ? 1 : ge + 1;
    le <= et ? ge : le;
    gm <= mt ? 1 : gm + 1;
    lm <= mt ? gm : lm;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [31:0] s, input [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask
  // read expectation queued by the driver, compared when read data appears
  task rd(input [11:0] a, input [31:0] x, input [31:0] msk);
    qe.push_back(x);
    qm.push_back(msk);
    apb(0, a, 0);
  endtask
  always @(posedge clk)
  begin
    if (psel && pen && !pwr && rdy)
    begin
      e = qe.pop_front();
      m = qm.pop_front();
      chk("prdata", prd & m, e);
    end
  end
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h278D));
    repeat (16) @(posedge clk);
    rst <= 0;
    // two full tick periods at the reset rate; 40 MHz / 9600 rounds to 4167 clocks
    repeat (8400) @(posedge clk);
    chk("ext rate", le, 4167);
    chk("modem rate", lm, 4167);
    $display("test rate done");
    for (int i = 0; i < 8; i++)
    begin
      k = i;
      sw = $urandom;
      sw[3:1] = {~k[0], ~k[1], ~k[2]};
      opt <= sw[7:0];
      repeat (3) @(posedge clk);
      chk("baud", bs, k);
      chk("parity", par, sw[0]);
      chk("iface", sgl, sw[4]);
      // the config word shows the inverted baud code in bits 3:1
      rd(12'h000, {26'h0, sw[5:4], ~k[2:0], sw[0]}, 32'hFFFFFFFF);
    end
    $display("test switch decode done");
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 8'hFF : 8'h4D;
      adr <= k[7:0];
      repeat (3) @(posedge clk);
      rv = {<<{k[7:0]}};
      chk("station", st, rv);
      chk("addr valid", va, k != 0);
    end
    remote_host_model_i.send(st);
    #1 chk("own accept", acc, 1);
    remote_host_model_i.send(8'h00);
    #1 chk("global accept", acc, 1);
    remote_host_model_i.send(st ^ 8'h5A);
    #1 chk("foreign drop", acc, 0);
    $display("test address done");
    for (int i = 0; i < 2; i++)
    begin
      opt <= i ? 8'h20 : 8'h00;
      apb(1, 12'h008, 1);
      remote_host_model_i.block;
      #1 chk("error reply", er, i);
    end
    apb(1, 12'h010, 1);
    rd(12'h00C, 0, 0);
    #1 chk("irq idle", irq, 0);
    key <= 1;
    repeat (2) @(posedge clk);
    #1 chk("irq key", irq, 1);
    rd(12'h00C, 1, 1);
    #1 chk("irq cleared", irq, 0);
    key <= 0;
    apb(1, 12'h010, 0);
    key <= 1;
    repeat (3) @(posedge clk);
    #1 chk("irq masked", irq, 0);
    key <= 0;
    $display("test interrupt done");
    apb(1, 12'h008, 8);
    #1 chk("lamp", lu, 1);
    cnt = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1 cnt += rf;
    end
    chk("refresh count", cnt, 3);
    chk("modem parity", mp, 0);
    chk("arbitration", arb, 0);
    chk("slverr", err, 0);
    rd(12'h01C, 32'h00002580, 32'hFFFFFFFF);
    rd(12'h020, 0, 32'hFFFFFFFF);
    $display("test panel done");
    opt <= 0;
    // a stored config before the memory test reports valid must be refused
    apb(1, 12'h000, 32'h0000000B);
    repeat (3) @(posedge clk);
    chk("cfg refused", par, 0);
    apb(1, 12'h008, 6);
    apb(1, 12'h000, 32'h0000000B);
    repeat (3) @(posedge clk);
    chk("stored parity", par, 1);
    chk("stored baud", bs, 2);
    $display("test restore done");
    results;
  end
endmodule // remote_link_config_test
